// *** sadc_pkg.sv ***
// Package of register map, field positions, reset values and timing counts for the SAR converter sequencer
package sadc_pkg;

	// ------------------------------------------------------------
	// Register byte addresses (APB, one aligned word each)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CONV_CONTROL_A = 8'h00;
	localparam logic [7:0] ADDR_CONV_CONTROL_B = 8'h04;
	localparam logic [7:0] ADDR_RESULT_HIGH    = 8'h08;
	localparam logic [7:0] ADDR_RESULT_LOW     = 8'h0c;

	// ------------------------------------------------------------
	// Field positions in conv_control_a
	// ------------------------------------------------------------
	localparam int CA_CHANNEL_MSB   = 7;
	localparam int CA_CHANNEL_LSB   = 4;
	localparam int CA_COMPLETION    = 3;
	localparam int CA_BUSY          = 2;
	localparam int CA_REF_SWITCH    = 1;
	localparam int CA_START         = 0;

	// ------------------------------------------------------------
	// Field positions in conv_control_b
	// ------------------------------------------------------------
	localparam int CB_EIGHT_BIT     = 7;
	localparam int CB_SAMPLE_MSB    = 6;
	localparam int CB_SAMPLE_LSB    = 5;
	localparam int CB_TRIG_SOURCE   = 4;
	localparam int CB_IRQ_ENABLE    = 3;
	localparam int CB_CONTINUOUS    = 2;
	localparam int CB_CLKSEL_MSB    = 1;
	localparam int CB_CLKSEL_LSB    = 0;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_CONTROL_A = 8'h00;
	localparam logic [7:0] RESET_CONTROL_B = 8'h00;
	localparam logic [9:0] RESET_RESULT    = 10'h000;
	localparam int         COMPARE_TICKS   = 10;   // Converter clocks of the compare period
	localparam int         NUM_CHANNELS    = 8;

	typedef enum logic [2:0] {
		SADC_IDLE,
		SADC_STARTUP,
		SADC_SAMPLE,
		SADC_COMPARE,
		SADC_LOAD
	} sadc_state_type;

endpackage

// *** sadc_clkdiv.sv ***
// Prescaler making one-cycle converter clock ticks from the machine clock
`timescale 1ns/1ps
module sadc_clkdiv
	import sadc_pkg::*;
#(
	parameter int DIV0 = 2,
	parameter int DIV1 = 4,
	parameter int DIV2 = 8,
	parameter int DIV3 = 16
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [1:0] clock_select,
	output logic            tick
);

	initial begin
		if (DIV0 < 2 || DIV1 < 2 || DIV2 < 2 || DIV3 < 2 || DIV0 > 255 || DIV1 > 255 || DIV2 > 255 || DIV3 > 255)
			$error("sadc_clkdiv: dividers must lie in 2..255");
	end

	logic [7:0] count;
	logic [7:0] div_sel;

	// Divider selection; held in reset while stopped so start alignment is known
	assign div_sel = (clock_select == 2'h0) ? 8'(DIV0) :
	                 (clock_select == 2'h1) ? 8'(DIV1) :
	                 (clock_select == 2'h2) ? 8'(DIV2) : 8'(DIV3);
	assign tick    = run && (count == div_sel - 8'h01);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			count <= 8'h00;
		else if (!run || tick)
			count <= 8'h00;
		else
			count <= count + 8'h01;
	end

endmodule // sadc_clkdiv

// *** sadc_sar.sv ***
// Successive approximation register: trial bits from MSB down to LSB
`timescale 1ns/1ps
module sadc_sar
	import sadc_pkg::*;
#(
	parameter int WIDTH = 10
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             begin_conv,
	input  wire logic             step,
	input  wire logic             comp_high,
	output logic [WIDTH-1:0]      trial,
	output logic [WIDTH-1:0]      value
);

	initial begin
		if (WIDTH < 2 || WIDTH > 16)
			$error("sadc_sar: WIDTH must lie in 2..16");
	end

	logic [WIDTH-1:0] mask;

	// Trial code presented to the DAC: decided bits plus current trial bit
	assign trial = value | mask;

	// ------------------------------------------------------------
	// Bit decision, MSB first
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			value <= '0;
			mask  <= '0;
		end else if (begin_conv) begin
			value <= '0;
			mask  <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (step && mask != '0) begin
			if (!comp_high)
				value <= value | mask;  // Input above trial level: keep the bit
			mask <= mask >> 1;          // Next lower bit
		end
	end

endmodule // sadc_sar

// *** sadc_top.sv ***
// Sequencer, APB register file and analog front-end control of the SAR converter
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - With continuous trigger enabled and trigger source 1, each rising trigger edge starts a conversion.
// - Continuous trigger enable at 0 stops edge-triggered starts.
// - Conversion start sets busy and connects the selected channel to sample-and-hold.
// - Sample phase charges hold capacitor; hold stays until conversion ends.
// - Result resolved MSB to LSB, then loaded into high and low registers.
// - With result load, busy clears unless a restart coincides, and completion flag sets.
// - Result registers keep the last value throughout a conversion.
// - Reset or stop mode halts the converter and clears busy.
// - Interrupt held while completion flag and enable are both 1.
// - Restart coinciding with completion still sets the completion flag.
// - Sampling lasts as many converter clocks as the sampling select picks.
// - Compare lasts ten converter clocks plus one machine clock.
// - Startup lasts from two machine clocks to one machine plus one converter clock.
// - Total time is startup plus sampling plus compare, within one converter clock.
// - Trigger source 1 selects composite timer output; 0 uses no external start.
// - Channel codes 0 to 7 select analog inputs zero to seven.
// - Interrupt needs flag and enable; flag sets regardless of enable.
// - Upper two result bits high, lower eight low; eight-bit mode zeros upper.
module sadc_top
	import sadc_pkg::*;
#(
	parameter int SAMPLE_TICKS0 = 4,
	parameter int SAMPLE_TICKS1 = 8,
	parameter int SAMPLE_TICKS2 = 16,
	parameter int SAMPLE_TICKS3 = 32
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// System
	input  wire logic        low_power_stop,
	input  wire logic        composite_timer_output,
	output logic             completion_irq,
	// Analog front end
	output logic [NUM_CHANNELS-1:0] analog_inputs_connect,
	output logic             sample_enable,
	output logic             hold_enable,
	output logic             reference_switch_control,
	output logic [9:0]       dac_code,
	input  wire logic        comparator_out
);

	// The phase counter is eight bits, so every sampling count must fit in it
	initial begin
		if (SAMPLE_TICKS0 < 1 || SAMPLE_TICKS0 > 255)
			$error("sadc_top: SAMPLE_TICKS0 must lie in 1..255");
		if (SAMPLE_TICKS1 < 1 || SAMPLE_TICKS1 > 255)
			$error("sadc_top: SAMPLE_TICKS1 must lie in 1..255");
		if (SAMPLE_TICKS2 < 1 || SAMPLE_TICKS2 > 255)
			$error("sadc_top: SAMPLE_TICKS2 must lie in 1..255");
		if (SAMPLE_TICKS3 < 1 || SAMPLE_TICKS3 > 255)
			$error("sadc_top: SAMPLE_TICKS3 must lie in 1..255");
	end

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	sadc_state_type state;
	logic [3:0] channel_select;
	logic       completion_flag;
	logic       busy_flag;
	logic       eight_bit_precision;
	logic [1:0] sampling_period_select;
	logic       trigger_source_select;
	logic       completion_irq_enable;
	logic       continuous_trigger_enable;
	logic [1:0] converter_clock_select;
	logic [9:0] result;
	logic [7:0] phase_count;
	logic [2:0] trig_sync;
	logic       trig_level;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        wr_access  = psel && penable && pwrite;
	wire        hit_a      = (paddr == ADDR_CONV_CONTROL_A);
	wire        hit_b      = (paddr == ADDR_CONV_CONTROL_B);
	wire        hit_h      = (paddr == ADDR_RESULT_HIGH);
	wire        hit_l      = (paddr == ADDR_RESULT_LOW);
	wire        mapped     = hit_a || hit_b || hit_h || hit_l;
	wire        wr_a       = wr_access && hit_a;
	wire        wr_b       = wr_access && hit_b;
	wire [7:0]  ctrl_a     = {channel_select, completion_flag, busy_flag, reference_switch_control, 1'b0};
	wire [7:0]  ctrl_b     = {eight_bit_precision, sampling_period_select, trigger_source_select,
	                          completion_irq_enable, continuous_trigger_enable, converter_clock_select};
	wire [7:0]  read_byte  = hit_a ? ctrl_a :
	                         hit_b ? ctrl_b :
	                         hit_h ? {6'h00, result[9:8]} :
	                         hit_l ? result[7:0] : 8'h00;

	// ------------------------------------------------------------
	// Start sources
	// ------------------------------------------------------------
	// Trigger pin edge counted once second and third stages agree
	wire trig_agree = (trig_sync[1] == trig_sync[2]);
	wire trig_rise  = trig_agree && trig_sync[1] && !trig_level;
	wire edge_start = trig_rise && continuous_trigger_enable && trigger_source_select;
	wire sw_start   = wr_a && pwdata[CA_START];
	wire start_conv = (sw_start || edge_start) && !low_power_stop;

	// ------------------------------------------------------------
	// Sequencer helpers
	// ------------------------------------------------------------
	logic tick;
	logic [9:0] sar_trial;
	logic [9:0] sar_value;
	wire [7:0] sample_len = (sampling_period_select == 2'h0) ? 8'(SAMPLE_TICKS0) :
	                        (sampling_period_select == 2'h1) ? 8'(SAMPLE_TICKS1) :
	                        (sampling_period_select == 2'h2) ? 8'(SAMPLE_TICKS2) : 8'(SAMPLE_TICKS3);
	wire [7:0] compare_len = 8'(COMPARE_TICKS);
	wire       phase_done  = tick && (phase_count == 8'h01);
	wire       running     = (state != SADC_IDLE);
	// Completion happens in the load cycle, even when a restart overrides the state
	wire       finish      = (state == SADC_LOAD);
	// Eight-bit mode keeps the top eight decided bits as the result
	wire [9:0] final_res   = eight_bit_precision ? {2'b00, sar_value[9:2]} : sar_value;

	sadc_clkdiv u_clkdiv (
		.mclk         (mclk),
		.rst          (rst),
		.run          (running && state != SADC_LOAD),
		.clock_select (converter_clock_select),
		.tick         (tick)
	);

	// The front end's comparator follows dac_code within the same mclk cycle, so it is read directly; a synchroniser
	// would make each decision see the previous trial at the fastest converter clock
	sadc_sar #(.WIDTH(10)) u_sar (
		.mclk       (mclk),
		.rst        (rst),
		.begin_conv (start_conv),
		.step       (state == SADC_COMPARE && tick),
		.comp_high  (comparator_out),
		.trial      (sar_trial),
		.value      (sar_value)
	);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trig_sync  <= 3'h0;
			trig_level <= 1'b0;
		end else begin
			trig_sync  <= {trig_sync[1:0], composite_timer_output};
			if (trig_agree)
				trig_level <= trig_sync[1];
		end
	end

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	// Start cycle plus the first converter tick form the startup delay
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state       <= SADC_IDLE;
			phase_count <= 8'h00;
		end else if (low_power_stop) begin
			state <= SADC_IDLE;
		end else if (start_conv) begin
			state       <= SADC_STARTUP;                  // Restart allowed mid conversion
			phase_count <= 8'h01;
		end else begin
			case (state)
				SADC_STARTUP: if (phase_done) begin
					state       <= SADC_SAMPLE;
					phase_count <= sample_len;
				end
				SADC_SAMPLE: if (phase_done) begin
					state       <= SADC_COMPARE;
					phase_count <= compare_len;
				end else if (tick) begin
					phase_count <= phase_count - 8'h01;
				end
				SADC_COMPARE: if (phase_done) begin
					state <= SADC_LOAD;                   // Extra machine clock of compare
				end else if (tick) begin
					phase_count <= phase_count - 8'h01;
				end
				SADC_LOAD: state <= SADC_IDLE;
				default:   state <= SADC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flags and results
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_flag       <= 1'b0;
			completion_flag <= 1'b0;
			result          <= RESET_RESULT;
		end else begin
			if (low_power_stop)
				busy_flag <= 1'b0;
			else if (start_conv)
				busy_flag <= 1'b1;
			else if (finish)
				busy_flag <= 1'b0;
			// Completion wins over a software clear and over a restart
			if (finish && !low_power_stop)
				completion_flag <= 1'b1;
			else if (wr_a && !pwdata[CA_COMPLETION])
				completion_flag <= 1'b0;
			if (finish && !low_power_stop)
				result <= final_res;                      // Only updated on completion
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{channel_select, reference_switch_control} <= {RESET_CONTROL_A[7:4], RESET_CONTROL_A[1]};
			{eight_bit_precision, sampling_period_select, trigger_source_select, completion_irq_enable,
			 continuous_trigger_enable, converter_clock_select} <= RESET_CONTROL_B;
		end else begin
			if (wr_a) begin
				channel_select           <= pwdata[CA_CHANNEL_MSB:CA_CHANNEL_LSB];
				reference_switch_control <= pwdata[CA_REF_SWITCH];
			end
			if (wr_b) begin
				eight_bit_precision       <= pwdata[CB_EIGHT_BIT];
				sampling_period_select    <= pwdata[CB_SAMPLE_MSB:CB_SAMPLE_LSB];
				trigger_source_select     <= pwdata[CB_TRIG_SOURCE];
				completion_irq_enable     <= pwdata[CB_IRQ_ENABLE];
				continuous_trigger_enable <= pwdata[CB_CONTINUOUS];
				converter_clock_select    <= pwdata[CB_CLKSEL_MSB:CB_CLKSEL_LSB];
			end
		end
	end

	// ------------------------------------------------------------
	// Bus response
	// ------------------------------------------------------------
	// Answer decided in the setup cycle, so pready rises in the first access cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;           // No wait state on any access
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Front-end controls and interrupt
	// ------------------------------------------------------------
	// Analog controls registered so the front end sees glitch-free levels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			completion_irq <= 1'b0;
			sample_enable  <= 1'b0;
			hold_enable    <= 1'b0;
			dac_code       <= 10'h000;
		end else begin
			completion_irq <= completion_flag && completion_irq_enable;
			sample_enable  <= (state == SADC_SAMPLE) && !low_power_stop;
			hold_enable    <= (state == SADC_COMPARE) && !low_power_stop;
			dac_code       <= sar_trial;
		end
	end

	// ------------------------------------------------------------
	// Channel switches
	// ------------------------------------------------------------
	// Only the selected input is closed, and only while converting; codes 8..15 close none
	// One flop per switch keeps each switch control straight from a flip-flop
	for (genvar g = 0; g < NUM_CHANNELS; g++) begin : gen_channel
		wire picked = running && !low_power_stop && (channel_select == 4'(g));
		always_ff @(posedge mclk or posedge rst) begin
			if (rst)
				analog_inputs_connect[g] <= 1'b0;
			else
				analog_inputs_connect[g] <= picked;
		end
	end

endmodule // sadc_top

// *** sadc_top_monitor.sv ***
// Concurrent checks on the ports of the SAR converter sequencer
`timescale 1ns/1ps
module sadc_top_monitor
	import sadc_pkg::*;
(
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    low_power_stop,
	input wire logic                    completion_irq,
	input wire logic [NUM_CHANNELS-1:0] analog_inputs_connect,
	input wire logic                    sample_enable,
	input wire logic                    hold_enable
);
	// ----------------------------------------------------------
	// Helper counter and assertions
	// ----------------------------------------------------------
	default clocking cb_main @(posedge mclk); endclocking
	default disable iff (rst);
	logic [11:0] hold_cnt;

	// Length of the current hold run, so the compare span can be bounded
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) hold_cnt <= 12'h000;
		else hold_cnt <= hold_enable ? hold_cnt + 12'h001 : 12'h000;
	end

	a_pready_after_setup: assert property (psel && !penable |=> pready) else $error("pready late");
	a_pready_has_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
	a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
	a_sample_hold_apart: assert property (!(sample_enable && hold_enable)) else $error("sample and hold");
	a_one_channel: assert property ($onehot0(analog_inputs_connect)) else $error("two channels");
	a_channel_steady: assert property (sample_enable && $past(sample_enable)
		|-> $stable(analog_inputs_connect)) else $error("channel moved");
	a_sample_to_hold: assert property ($fell(sample_enable) && !low_power_stop && !$past(low_power_stop)
		|-> ##[0:2] hold_enable) else $error("no hold after sample");
	a_compare_length: assert property ($fell(hold_enable) && !$past(low_power_stop)
		|-> hold_cnt >= 12'h00a) else $error("compare short");
	a_stop_halts: assert property (low_power_stop [*3] |-> !sample_enable && !hold_enable)
		else $error("stop ignored");
	a_irq_needs_clear: assert property ($fell(completion_irq) |-> $past(psel && penable && pwrite)
		|| $past(psel && penable && pwrite, 2)) else $error("irq dropped");
	c_compare: cover property ($fell(hold_enable));
	c_irq: cover property ($rose(completion_irq));
	c_slverr: cover property (pslverr);
endmodule // sadc_top_monitor

bind sadc_top sadc_top_monitor u_sadc_top_monitor (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .low_power_stop(low_power_stop), .completion_irq(completion_irq),
	.analog_inputs_connect(analog_inputs_connect), .sample_enable(sample_enable), .hold_enable(hold_enable)
);

// *** sadc_afe_model.sv ***
// Behavioural analog front end: eight input levels, hold capacitor and comparator
`timescale 1ns/1ps
module sadc_afe_model
	import sadc_pkg::*;
(
	input  wire logic                    mclk,
	input  wire logic [NUM_CHANNELS-1:0] analog_inputs_connect,
	input  wire logic                    sample_enable,
	input  wire logic [9:0]              dac_code,
	output logic                         comparator_out
);
	// ----------------------------------------------------------
	// Hold capacitor and comparator
	// ----------------------------------------------------------
	logic [9:0] held = 10'h155;

	// Charge from the connected input; an open input leaves the cap drifting
	always @(posedge mclk) begin
		if (sample_enable === 1'b1) begin
			held <= ~held;
			for (int i = 0; i < NUM_CHANNELS; i++)
				if (analog_inputs_connect[i] === 1'b1) held <= 10'h3ff - 10'(i) * 10'h05b;
		end
	end

	// High when the trial code lies above the held voltage
	assign comparator_out = dac_code > held;
endmodule // sadc_afe_model

// *** sadc_sequencer_test.sv ***
// Self-checking testbench of the SAR converter sequencer
`timescale 1ns/1ps
module sadc_sequencer_test;
	import sadc_pkg::*;
	// ----------------------------------------------------------
	// Signals, design and front-end model
	// ----------------------------------------------------------
	logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, low_power_stop = 1'b0, composite_timer_output = 1'b0, completion_irq;
	logic [7:0]  conn_seen, analog_inputs_connect;
	logic        sample_enable, hold_enable, reference_switch_control, comparator_out, serr, seen;
	logic [9:0]  dac_code, last = 10'h000;
	logic [31:0] q;
	int          err_total = 0, checks = 0, s_run = 0, s_len = 0, h_run = 0, h_len = 0;
	logic [11:0] rows [8] = '{12'h000, 12'h128, 12'h241, 12'h369, 12'h402, 12'h52a, 12'h643, 12'h76b};
	logic [7:0]  trig_cb [4] = '{8'h14, 8'h14, 8'h10, 8'h04};

	always #12.5 mclk = ~mclk;
	sadc_top u_sadc_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.low_power_stop(low_power_stop), .composite_timer_output(composite_timer_output),
		.completion_irq(completion_irq), .analog_inputs_connect(analog_inputs_connect),
		.sample_enable(sample_enable), .hold_enable(hold_enable),
		.reference_switch_control(reference_switch_control), .dac_code(dac_code), .comparator_out(comparator_out));
	sadc_afe_model u_sadc_afe_model (.mclk(mclk), .analog_inputs_connect(analog_inputs_connect),
		.sample_enable(sample_enable), .dac_code(dac_code), .comparator_out(comparator_out));

	// Run lengths of sampling and compare, and the channel seen while sampling
	always @(posedge mclk) begin
		if (sample_enable === 1'b1) begin s_run <= s_run + 1; conn_seen <= analog_inputs_connect; end
		else if (s_run != 0) begin s_len <= s_run; s_run <= 0; end
		if (hold_enable === 1'b1) h_run <= h_run + 1;
		else if (h_run != 0) begin h_len <= h_run; h_run <= 0; end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin err_total++; $display("BAD %s expected %h seen %h", nm, e, s); end
	endtask

	// One APB transfer; request held until the rising edge that sees pready, data taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin @(posedge mclk); end while (pready !== 1'b1);
		r = prdata;
		serr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic wait_idle(output logic [31:0] r);
		int n;
		n = 0;
		do begin apb(1'b0, ADDR_CONV_CONTROL_A, 32'h0, r); n++; end while (r[CA_BUSY] !== 1'b0 && n < 400);
		chk("idle", 32'h0, 32'(r[CA_BUSY]));
	endtask

	task automatic wait_samp(input int lim, output logic s);
		s = 1'b0;
		repeat (lim) begin @(negedge mclk); if (sample_enable === 1'b1) s = 1'b1; end
	endtask

	// Software-started conversion with timing, result and flag checks
	task automatic conv(input logic [3:0] ch, input logic [7:0] cb, input logic eight);
		logic [9:0] ex;
		int dv;
		ex = 10'h3ff - 10'(ch) * 10'h05b;
		if (eight) ex = {2'b00, ex[9:2]};
		dv = 2 << cb[1:0];
		apb(1'b1, ADDR_CONV_CONTROL_B, {24'h0, cb}, q);
		apb(1'b1, ADDR_CONV_CONTROL_A, {24'h0, ch, 4'h1}, q);
		apb(1'b0, ADDR_CONV_CONTROL_A, 32'h0, q);
		chk("busy", 32'h1, 32'(q[CA_BUSY]));
		apb(1'b0, ADDR_RESULT_LOW, 32'h0, q);
		chk("old result", {24'h0, last[7:0]}, q);
		wait_idle(q);
		chk("completion", 32'h1, 32'(q[CA_COMPLETION]));
		chk("irq", 32'(cb[CB_IRQ_ENABLE]), 32'(completion_irq));
		chk("channel", 32'(8'h01 << ch), 32'(conn_seen));
		chk("sample len", 32'((4 << cb[6:5]) * dv), 32'(s_len));
		chk("compare len", 32'h1, 32'(h_len >= 10 * dv && h_len <= 10 * dv + 1));
		apb(1'b0, ADDR_RESULT_HIGH, 32'h0, q);
		chk("result high", {30'h0, ex[9:8]}, q);
		apb(1'b0, ADDR_RESULT_LOW, 32'h0, q);
		chk("result low", {24'h0, ex[7:0]}, q);
		apb(1'b1, ADDR_CONV_CONTROL_A, {24'h0, ch, 4'h0}, q);
		apb(1'b0, ADDR_CONV_CONTROL_A, 32'h0, q);
		chk("cleared", 32'h0, 32'({completion_irq, q[CA_COMPLETION]}));
		last = ex;
	endtask

	task automatic print_verdict();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Watchdog at about eight times the longest expected run
	initial begin #500000; err_total++; print_verdict(); end

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, ADDR_CONV_CONTROL_B, 32'h0, q);
		chk("reset control b", {24'h0, RESET_CONTROL_B}, q);
		for (int i = 0; i < 8; i++) conv(rows[i][11:8], rows[i][7:0], 1'b0);
		// Read-only result and unmapped address
		apb(1'b1, ADDR_RESULT_LOW, 32'h0, q);
		apb(1'b0, ADDR_RESULT_LOW, 32'h0, q);
		chk("result read only", {24'h0, last[7:0]}, q);
		apb(1'b0, 8'h10, 32'h0, q);
		chk("unmapped", 32'h1, {q[30:0], serr});
		conv(4'h1, 8'h80, 1'b1);
		// Trigger edges: start only with source and continuous mode both set
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ADDR_CONV_CONTROL_B, {24'h0, trig_cb[i]}, q);
			composite_timer_output <= 1'b0;
			wait_samp(10, seen);
			@(posedge mclk);
			composite_timer_output <= 1'b1;
			wait_samp(60, seen);
			chk("trigger start", 32'(i < 2), 32'(seen));
			wait_idle(q);
		end
		// Stop mode in mid-sample aborts without completion
		apb(1'b1, ADDR_CONV_CONTROL_A, 32'h20, q);
		apb(1'b1, ADDR_CONV_CONTROL_B, 32'h63, q);
		apb(1'b1, ADDR_CONV_CONTROL_A, 32'h21, q);
		wait_samp(20, seen);
		@(posedge mclk);
		low_power_stop <= 1'b1;
		repeat (4) @(posedge mclk);
		apb(1'b0, ADDR_CONV_CONTROL_A, 32'h0, q);
		chk("stop halts", 32'h1, 32'({q[CA_BUSY], q[CA_COMPLETION], seen}));
		low_power_stop <= 1'b0;
		// Reset in mid-conversion halts it and brings the registers back
		apb(1'b1, ADDR_CONV_CONTROL_A, 32'h21, q);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, ADDR_CONV_CONTROL_A, 32'h0, q);
		chk("reset halts", 32'h0, q);
		apb(1'b0, ADDR_RESULT_LOW, 32'h0, q);
		chk("reset result", {24'h0, RESET_RESULT[7:0]}, q);
		print_verdict();
	end
endmodule // sadc_sequencer_test
